// ### inc/rbc_regs.svh
`ifndef RBC_REGS_SVH
`define RBC_REGS_SVH

// bus widths
`define RBC_BYTE_W 8
`define RBC_WORD_W 16
`define RBC_BANK_A 7:0
`define RBC_BANK_B 15:8
`define RBC_ADDR_W 16
`define RBC_HADDR_W 2

// host register offsets and reset values
`define RBC_REG_MODE 2'h0
`define RBC_REG_HORIZONTAL_DELAY_COUNT 2'h1
`define RBC_REG_VERTICAL_DELAY_COUNT 2'h2
`define RBC_REG_SCAN 2'h3
`define RBC_MODE_RST 8'h00
`define RBC_DELAY_RST 8'h00
`define RBC_SCAN_RST 8'h01
`define RBC_GO_BIT 0

// 8x8 block of 64 bytes
`define RBC_BLK_IDX_W 6
`define RBC_BLK_LAST 6'h3f

// two-entry byte buffer
`define RBC_BUF_DEPTH 2
`define RBC_LVL_W 2
`define RBC_BUF_FULL 2'h2

// host pins pass a two-stage synchroniser: sel, addr, wr_n, rd_n, data
`define RBC_SYNC_W 13
`define RBC_SYNC_RST 13'h0300

`endif

// ### inc/rbc_pkg.sv
package rbc_pkg;

    typedef enum logic [2:0] {
        RBC_TX_IDLE = 3'b001,
        RBC_TX_SYNC = 3'b010,
        RBC_TX_DATA = 3'b100
    } rbc_tx_state_t;

endpackage

// ### verilog/rbc_sync.sv
`timescale 1ns/100ps
`default_nettype none
`include "rbc_regs.svh"

module rbc_sync (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic [`RBC_SYNC_W-1:0] i_async,
    output logic [`RBC_SYNC_W-1:0] o_sync
);

    logic [`RBC_SYNC_W-1:0] meta_r;
    logic [`RBC_SYNC_W-1:0] sync_r;

    // strobes reset to their idle (high) level so no false edge appears
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_r <= `RBC_SYNC_RST;
            sync_r <= `RBC_SYNC_RST;
        end else begin
            meta_r <= i_async;
            sync_r <= meta_r;
        end
    end

    assign o_sync = sync_r;

endmodule

`default_nettype wire

// ### verilog/rbc_buf.sv
`timescale 1ns/100ps
`default_nettype none
`include "rbc_regs.svh"

module rbc_buf (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic [`RBC_BYTE_W-1:0] i_in_data,
    input wire logic i_in_valid,
    output logic o_in_ready,
    output logic [`RBC_BYTE_W-1:0] o_out_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [`RBC_LVL_W-1:0] o_level
);

    logic [`RBC_BYTE_W-1:0] mem_r [`RBC_BUF_DEPTH];
    logic wr_idx_r;
    logic rd_idx_r;
    logic [`RBC_LVL_W-1:0] cnt_r;
    logic push;
    logic pop;

    assign o_in_ready = (cnt_r != `RBC_BUF_FULL);
    assign o_out_valid = (cnt_r != '0);
    assign o_out_data = mem_r[rd_idx_r];
    assign o_level = cnt_r;
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    always_ff @(posedge i_mclk) begin
        if (push) begin
            mem_r[wr_idx_r] <= i_in_data;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_idx_r <= 1'b0;
            rd_idx_r <= 1'b0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wr_idx_r <= ~wr_idx_r;
            end
            if (pop) begin
                rd_idx_r <= ~rd_idx_r;
            end
            cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
        end
    end

endmodule

`default_nettype wire

// ### verilog/rbc_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "rbc_regs.svh"

module rbc_top (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic [`RBC_WORD_W-1:0] i_pixel_bus,
    output logic [`RBC_WORD_W-1:0] o_pixel_bus,
    output logic o_pixel_bus_oe,
    input wire logic i_line_enable,
    input wire logic i_frame_enable,
    input wire logic i_host_select,
    input wire logic [`RBC_HADDR_W-1:0] i_host_addr,
    input wire logic i_host_wr_n,
    input wire logic i_host_rd_n,
    output logic [`RBC_ADDR_W-1:0] o_strip_mem_addr,
    input wire logic [`RBC_WORD_W-1:0] i_strip_mem_data,
    output logic [`RBC_WORD_W-1:0] o_strip_mem_data,
    output logic o_strip_mem_data_oe,
    output logic o_strip_mem_write_n,
    output logic o_strip_mem_output_n,
    input wire logic [`RBC_BYTE_W-1:0] i_codec_byte_bus,
    output logic [`RBC_BYTE_W-1:0] o_codec_byte_bus,
    output logic o_codec_byte_bus_oe,
    input wire logic i_block_sync_n,
    output logic o_block_sync_n,
    output logic o_block_sync_oe,
    input wire logic i_stop_n,
    output logic o_stop_n,
    output logic o_stop_oe,
    input wire logic i_end_of_scan_n,
    output logic o_end_of_scan_n,
    output logic o_end_of_scan_oe,
    input wire logic i_codec_output_enable
);

    logic [`RBC_SYNC_W-1:0] host_sync;
    logic host_select_s;
    logic [`RBC_HADDR_W-1:0] host_addr_s;
    logic host_wr_n_s;
    logic host_rd_n_s;
    logic [`RBC_BYTE_W-1:0] host_data_s;
    logic host_wr_n_d_r;
    logic host_wr;
    logic host_rd;
    logic [`RBC_BYTE_W-1:0] mode_r;
    logic [`RBC_BYTE_W-1:0] horizontal_delay_count_r;
    logic [`RBC_BYTE_W-1:0] vertical_delay_count_r;
    logic [`RBC_BYTE_W-1:0] scan_blocks_r;
    logic [`RBC_BYTE_W-1:0] blk_cnt_r;
    logic [`RBC_BYTE_W-1:0] rd_data_nxt;
    logic go;
    logic comp;
    logic line_d_r;
    logic frame_d_r;
    logic line_rise;
    logic frame_rise;
    logic [`RBC_BYTE_W-1:0] hcount_r;
    logic [`RBC_BYTE_W-1:0] vcount_r;
    logic active;
    logic [`RBC_ADDR_W-1:0] wr_ptr_r;
    logic [`RBC_ADDR_W-1:0] rd_ptr_r;
    logic mem_wreq;
    logic mem_rreq;
    logic do_wr;
    logic do_rd;
    logic word_free;
    logic rd_done;
    logic [`RBC_WORD_W-1:0] word_r;
    logic word_v_r;
    logic byte_hi_r;
    logic [`RBC_BYTE_W-1:0] buf_in_data;
    logic buf_in_valid;
    logic buf_in_ready;
    logic [`RBC_BYTE_W-1:0] buf_out_data;
    logic buf_out_valid;
    logic buf_out_ready;
    logic [`RBC_LVL_W-1:0] buf_level;
    logic [`RBC_LVL_W-1:0] level_after;
    logic buf_pop;
    rbc_pkg::rbc_tx_state_t tx_st_r;
    logic [`RBC_BLK_IDX_W-1:0] tx_idx_r;
    logic tx_pop;
    logic blk_last;
    logic scan_last;
    logic rx_on_r;
    logic [`RBC_BLK_IDX_W-1:0] rx_idx_r;
    logic take;
    logic scan_done;

    // host pins are asynchronous to the system clock
    rbc_sync u_sync (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_async({i_host_select, i_host_addr, i_host_wr_n, i_host_rd_n,
                  i_pixel_bus[`RBC_BANK_A]}),
        .o_sync(host_sync)
    );

    assign {host_select_s, host_addr_s, host_wr_n_s, host_rd_n_s, host_data_s} = host_sync;

    // write lands on the rising edge of the write strobe
    assign host_wr = host_select_s && host_wr_n_s && !host_wr_n_d_r;
    assign host_rd = host_select_s && !host_rd_n_s;
    assign go = mode_r[`RBC_GO_BIT];
    assign comp = i_codec_output_enable;

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            host_wr_n_d_r <= 1'b1;
        end else begin
            host_wr_n_d_r <= host_wr_n_s;
        end
    end

    // hardware clears go at end of scan; a host write to the mode register in that cycle wins
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mode_r <= `RBC_MODE_RST;
            horizontal_delay_count_r <= `RBC_DELAY_RST;
            vertical_delay_count_r <= `RBC_DELAY_RST;
            scan_blocks_r <= `RBC_SCAN_RST;
        end else begin
            if (host_wr && host_addr_s == `RBC_REG_MODE) begin
                mode_r <= host_data_s;
            end else if (scan_done) begin
                mode_r[`RBC_GO_BIT] <= 1'b0;
            end
            if (host_wr && host_addr_s == `RBC_REG_HORIZONTAL_DELAY_COUNT) begin
                horizontal_delay_count_r <= host_data_s;
            end
            if (host_wr && host_addr_s == `RBC_REG_VERTICAL_DELAY_COUNT) begin
                vertical_delay_count_r <= host_data_s;
            end
            if (host_wr && host_addr_s == `RBC_REG_SCAN) begin
                scan_blocks_r <= host_data_s;
            end
        end
    end

    always_comb begin
        unique case (host_addr_s)
            `RBC_REG_MODE: rd_data_nxt = mode_r;
            `RBC_REG_HORIZONTAL_DELAY_COUNT: rd_data_nxt = horizontal_delay_count_r;
            `RBC_REG_VERTICAL_DELAY_COUNT: rd_data_nxt = vertical_delay_count_r;
            `RBC_REG_SCAN: rd_data_nxt = blk_cnt_r;
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pixel_bus_oe <= 1'b0;
            o_pixel_bus <= '0;
        end else if (host_select_s) begin
            o_pixel_bus_oe <= host_rd;
            o_pixel_bus <= {{`RBC_BYTE_W{1'b0}}, rd_data_nxt};
        end else begin
            o_pixel_bus_oe <= go && !comp;
            if (rd_done && !comp) begin
                o_pixel_bus <= i_strip_mem_data;
            end
        end
    end

    // raster window: both delays must have run out
    assign line_rise = i_line_enable && !line_d_r;
    assign frame_rise = i_frame_enable && !frame_d_r;
    assign active = go && i_frame_enable && i_line_enable
                    && (line_rise ? horizontal_delay_count_r == '0 : hcount_r == '0)
                    && (frame_rise ? vertical_delay_count_r == '0 : vcount_r == '0);

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            line_d_r <= 1'b0;
            frame_d_r <= 1'b0;
            hcount_r <= '0;
            vcount_r <= '0;
        end else begin
            line_d_r <= i_line_enable;
            frame_d_r <= i_frame_enable;
            if (line_rise) begin
                hcount_r <= horizontal_delay_count_r;
            end else if (hcount_r != '0) begin
                hcount_r <= hcount_r - 1'b1;
            end
            if (frame_rise) begin
                vcount_r <= vertical_delay_count_r;
            end else if (line_rise && vcount_r != '0) begin
                vcount_r <= vcount_r - 1'b1;
            end
        end
    end

    // one access per cycle; the raster side has priority in both modes
    // because the pixel stream cannot be stalled
    assign rd_done = !o_strip_mem_output_n;
    assign mem_wreq = comp ? active : word_v_r;
    // the codec link has no valid strobe, so reads overlap the byte split: a read
    // goes out once the word register is empty, or holds only a last byte with room
    // for it, at the edge the data arrives
    assign word_free = !word_v_r || (byte_hi_r && buf_in_ready)
                       || ((byte_hi_r || buf_in_ready) && level_after != `RBC_BUF_FULL);
    assign mem_rreq = comp ? (rd_ptr_r != wr_ptr_r && word_free && o_strip_mem_output_n)
                           : (active && rd_ptr_r != wr_ptr_r);
    assign do_wr = comp ? mem_wreq : (mem_wreq && !mem_rreq);
    assign do_rd = comp ? (mem_rreq && !mem_wreq) : mem_rreq;

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_strip_mem_addr <= '0;
            o_strip_mem_data <= '0;
            o_strip_mem_data_oe <= 1'b0;
            o_strip_mem_write_n <= 1'b1;
            o_strip_mem_output_n <= 1'b1;
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            o_strip_mem_write_n <= !do_wr;
            o_strip_mem_output_n <= !do_rd;
            o_strip_mem_data_oe <= do_wr;
            if (do_wr) begin
                o_strip_mem_addr <= wr_ptr_r;
                o_strip_mem_data <= comp ? i_pixel_bus : word_r;
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end else if (do_rd) begin
                o_strip_mem_addr <= rd_ptr_r;
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end

    // word_r splits memory words into bytes when compressing and
    // pairs codec bytes into memory words when expanding
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            word_r <= '0;
            word_v_r <= 1'b0;
            byte_hi_r <= 1'b0;
        end else if (comp) begin
            if (rd_done) begin
                word_r <= i_strip_mem_data;
                word_v_r <= 1'b1;
                byte_hi_r <= 1'b0;
            end else if (word_v_r && buf_in_ready) begin
                byte_hi_r <= !byte_hi_r;
                word_v_r <= !byte_hi_r;
            end
        end else begin
            if (do_wr) begin
                word_v_r <= 1'b0;
            end else if (buf_pop) begin
                if (byte_hi_r) begin
                    word_r[`RBC_BANK_B] <= buf_out_data;
                    word_v_r <= 1'b1;
                end else begin
                    word_r[`RBC_BANK_A] <= buf_out_data;
                end
                byte_hi_r <= !byte_hi_r;
            end
        end
    end

    assign buf_in_data = !comp ? i_codec_byte_bus
                       : byte_hi_r ? word_r[`RBC_BANK_B] : word_r[`RBC_BANK_A];
    assign buf_in_valid = comp ? word_v_r : take;
    assign buf_out_ready = comp ? tx_pop : !word_v_r;
    assign buf_pop = buf_out_valid && buf_out_ready;

    rbc_buf u_buf (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_in_data(buf_in_data),
        .i_in_valid(buf_in_valid),
        .o_in_ready(buf_in_ready),
        .o_out_data(buf_out_data),
        .o_out_valid(buf_out_valid),
        .i_out_ready(buf_out_ready),
        .o_level(buf_level)
    );

    // compression: sync cycle pops byte 0 so it shows exactly one cycle later
    assign tx_pop = (tx_st_r == rbc_pkg::RBC_TX_SYNC)
                    || (tx_st_r == rbc_pkg::RBC_TX_DATA && buf_out_valid && i_stop_n);
    assign blk_last = (tx_idx_r == `RBC_BLK_LAST);
    assign scan_last = (blk_cnt_r + 1'b1 == scan_blocks_r);

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tx_st_r <= rbc_pkg::RBC_TX_IDLE;
            tx_idx_r <= '0;
            o_block_sync_n <= 1'b1;
            o_end_of_scan_n <= 1'b1;
            o_codec_byte_bus <= '0;
        end else begin
            o_block_sync_n <= 1'b1;
            o_end_of_scan_n <= 1'b1;
            unique case (tx_st_r)
                rbc_pkg::RBC_TX_IDLE: begin
                    if (comp && go && buf_out_valid && i_stop_n) begin
                        o_block_sync_n <= 1'b0;
                        tx_st_r <= rbc_pkg::RBC_TX_SYNC;
                        tx_idx_r <= '0;
                    end
                end
                rbc_pkg::RBC_TX_SYNC: begin
                    tx_st_r <= rbc_pkg::RBC_TX_DATA;
                end
                rbc_pkg::RBC_TX_DATA: begin
                    if (tx_pop && blk_last) begin
                        tx_st_r <= rbc_pkg::RBC_TX_IDLE;
                    end
                end
            endcase
            if (tx_pop) begin
                o_codec_byte_bus <= buf_out_data;
                tx_idx_r <= tx_idx_r + 1'b1;
                if (blk_last && scan_last) begin
                    o_end_of_scan_n <= 1'b0;
                end
            end
        end
    end

    // expansion: a byte is taken in every cycle of a block that stop is high
    assign take = !comp && rx_on_r && o_stop_n;
    assign level_after = buf_level + {1'b0, buf_in_valid && buf_in_ready} - {1'b0, buf_pop};
    assign scan_done = comp ? (tx_pop && blk_last && scan_last)
                            : (take && !i_end_of_scan_n);

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rx_on_r <= 1'b0;
            rx_idx_r <= '0;
            o_stop_n <= 1'b1;
            blk_cnt_r <= '0;
        end else begin
            // room for one more byte next cycle, or stop the codec
            o_stop_n <= comp || (level_after != `RBC_BUF_FULL);
            if (!comp && go && !i_block_sync_n) begin
                rx_on_r <= 1'b1;
                rx_idx_r <= '0;
            end else if (take) begin
                rx_idx_r <= rx_idx_r + 1'b1;
                if (rx_idx_r == `RBC_BLK_LAST || !i_end_of_scan_n) begin
                    rx_on_r <= 1'b0;
                end
            end
            if (scan_done) begin
                blk_cnt_r <= '0;
            end else if ((take && rx_idx_r == `RBC_BLK_LAST) || (tx_pop && blk_last)) begin
                blk_cnt_r <= blk_cnt_r + 1'b1;
            end
        end
    end

    // link drivers turn with the codec's direction control
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_codec_byte_bus_oe <= 1'b0;
            o_block_sync_oe <= 1'b0;
            o_end_of_scan_oe <= 1'b0;
            o_stop_oe <= 1'b0;
        end else begin
            o_codec_byte_bus_oe <= comp;
            o_block_sync_oe <= comp;
            o_end_of_scan_oe <= comp;
            o_stop_oe <= !comp;
        end
    end

endmodule

`default_nettype wire

// ### testbench/rbc_top_sva.sv
`timescale 1ns/100ps
`default_nettype none
module rbc_top_sva (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic [15:0] o_pixel_bus,
    input wire logic o_pixel_bus_oe,
    input wire logic i_host_select,
    input wire logic i_host_rd_n,
    input wire logic o_strip_mem_data_oe,
    input wire logic o_strip_mem_write_n,
    input wire logic o_strip_mem_output_n,
    input wire logic [7:0] o_codec_byte_bus,
    input wire logic o_codec_byte_bus_oe,
    input wire logic o_block_sync_n,
    input wire logic o_block_sync_oe,
    input wire logic i_stop_n,
    input wire logic o_stop_oe,
    input wire logic o_end_of_scan_n,
    input wire logic o_end_of_scan_oe,
    input wire logic i_codec_output_enable
);
    default clocking dc @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_n);

    reset_float_a: assert property (disable iff (1'b0)
        !i_rst_n |-> !(o_pixel_bus_oe || o_codec_byte_bus_oe || o_stop_oe || o_strip_mem_data_oe))
        else $error("pin driven in reset");
    mode_oe_a: assert property ($past(i_rst_n) |->
        o_codec_byte_bus_oe == $past(i_codec_output_enable)) else $error("byte bus oe wrong");
    oe_group_a: assert property ($past(i_rst_n) |->
        o_block_sync_oe == o_codec_byte_bus_oe &&
        o_end_of_scan_oe == o_codec_byte_bus_oe && o_stop_oe != o_codec_byte_bus_oe)
        else $error("codec oe group split");
    sync_width_a: assert property ($fell(o_block_sync_n) |=> o_block_sync_n)
        else $error("sync wider than one cycle");
    sync_dir_a: assert property (!o_block_sync_n |-> o_block_sync_oe)
        else $error("sync while not driving");
    eos_dir_a: assert property (!o_end_of_scan_n |-> o_end_of_scan_oe)
        else $error("end of scan while not driving");
    stop_hold_a: assert property (o_codec_byte_bus_oe && o_block_sync_n && !i_stop_n
        |=> $stable(o_codec_byte_bus)) else $error("byte moved under stop");
    host_drive_a: assert property ((i_host_select && !i_host_rd_n) [*4] |->
        o_pixel_bus_oe && o_pixel_bus[15:8] == 8'h00) else $error("host read not driven");
    host_float_a: assert property ((i_host_select && i_host_rd_n) [*4] |->
        !o_pixel_bus_oe) else $error("pixel bus driven without read");
    comp_float_a: assert property ((o_codec_byte_bus_oe && !i_host_select) [*4] |->
        !o_pixel_bus_oe) else $error("pixel bus driven in compression");
    strobe_a: assert property (o_strip_mem_data_oe == !o_strip_mem_write_n &&
        (o_strip_mem_write_n || o_strip_mem_output_n)) else $error("strip strobes clash");
endmodule

bind rbc_top rbc_top_sva i_rbc_top_sva (.i_mclk, .i_rst_n, .o_pixel_bus, .o_pixel_bus_oe,
    .i_host_select, .i_host_rd_n, .o_strip_mem_data_oe, .o_strip_mem_write_n,
    .o_strip_mem_output_n, .o_codec_byte_bus, .o_codec_byte_bus_oe, .o_block_sync_n,
    .o_block_sync_oe, .i_stop_n, .o_stop_oe, .o_end_of_scan_n, .o_end_of_scan_oe,
    .i_codec_output_enable);
`default_nettype wire

// ### testbench/rbc_codec_model.sv
`timescale 1ns/100ps
`default_nettype none
module rbc_codec_model (
    input wire logic i_mclk,
    input wire logic i_mode,
    output logic o_coe,
    input wire logic [7:0] i_byte,
    output logic [7:0] o_byte = 8'h5a,
    input wire logic i_sync_n,
    output logic o_sync_n = 1'b1,
    input wire logic i_stop_n,
    output logic o_stop_n = 1'b1,
    input wire logic i_eos_n,
    output logic o_eos_n = 1'b1
);
    logic [7:0] rx_q[$];
    logic pend = 1'b0, inblk = 1'b0, sending = 1'b0, hold_off = 1'b0;
    int cnt = 0, eos_at = 0, n_to = 0;

    assign o_coe = i_mode;

    // a byte launched at one edge is picked up at the next one
    always @(posedge i_mclk) begin
        if (pend) begin
            rx_q.push_back(i_byte);
            if (!i_eos_n) eos_at = rx_q.size();
        end
        pend <= o_coe && (!i_sync_n || (inblk && i_stop_n));
        if (o_coe && !i_sync_n) begin
            cnt <= 1;
            inblk <= 1'b1;
        end else if (inblk && i_stop_n) begin
            cnt <= cnt + 1;
            inblk <= cnt < 63;
        end
    end

    // random stalls exercise the byte hold; hold_off parks the link while idle
    always @(negedge i_mclk) begin
        o_stop_n <= !hold_off && !(inblk && $urandom_range(3) == 0);
        if (!sending) o_byte <= ~o_byte;
    end

    task automatic send_blk(input logic [7:0] b [64]);
        int t;
        @(negedge i_mclk);
        sending = 1'b1;
        o_sync_n = 1'b0;
        @(negedge i_mclk);
        o_sync_n = 1'b1;
        for (int i = 0; i < 64; i++) begin
            o_byte = b[i];
            o_eos_n = i != 63;
            t = 0;
            @(posedge i_mclk);
            while (!i_stop_n && t < 500) begin
                t++;
                @(posedge i_mclk);
            end
            n_to += int'(t == 500);
            @(negedge i_mclk);
        end
        o_eos_n = 1'b1;
        sending = 1'b0;
    endtask
endmodule
`default_nettype wire

// ### testbench/rbc_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "rbc_regs.svh"
module rbc_tb_top;
    logic i_mclk = 1'b0;
    logic i_rst_n = 1'b1;
    logic hsel = 1'b0, wr_n = 1'b1, rd_n = 1'b1, line_en = 1'b0, frame_en = 1'b0, mode = 1'b1;
    logic [1:0] haddr = 2'h0;
    logic [15:0] px_drv = 16'h0000, sm_last = 16'h0000;
    logic [15:0] px_out, px_w, sm_out, sm_in, addr;
    logic px_oe, sm_oe, we_n, oe_n, b_oe, s_oe, st_oe, e_oe, d_sync_n, d_stop_n, d_eos_n;
    logic c_coe, c_sync_n, c_stop_n, c_eos_n, w_sync_n, w_stop_n, w_eos_n;
    logic exp_ph = 1'b0, rd_q = 1'b0;
    logic [7:0] b_out, c_byte, w_byte;
    logic [15:0] mem [0:65535];
    logic [15:0] wlog[$], pq[$], wexp[$];
    logic [7:0] bexp [64];
    int n_mismatch = 0, checked = 0, n_sync = 0;

    assign px_w = (px_oe === 1'b1) ? px_out : px_drv;
    assign w_byte = (b_oe === 1'b1) ? b_out : c_byte;
    assign w_sync_n = (s_oe === 1'b1) ? d_sync_n : c_sync_n;
    assign w_stop_n = (st_oe === 1'b1) ? d_stop_n : c_stop_n;
    assign w_eos_n = (e_oe === 1'b1) ? d_eos_n : c_eos_n;
    // an undriven strip bus must not keep showing the last word
    assign sm_in = (oe_n === 1'b0) ? mem[addr] : ~sm_last;

    initial forever #10 i_mclk = ~i_mclk;

    always @(posedge i_mclk) begin
        if (we_n === 1'b0) wlog.push_back(sm_out);
        if (we_n === 1'b0) mem[addr] <= sm_out;
        if (oe_n === 1'b0) sm_last <= mem[addr];
        if (rd_q && exp_ph) pq.push_back(px_out);
        rd_q <= oe_n === 1'b0;
        if (s_oe === 1'b1 && d_sync_n === 1'b0) n_sync++;
    end

    rbc_top i_rbc_top (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_pixel_bus(px_w),
        .o_pixel_bus(px_out), .o_pixel_bus_oe(px_oe), .i_line_enable(line_en),
        .i_frame_enable(frame_en), .i_host_select(hsel), .i_host_addr(haddr),
        .i_host_wr_n(wr_n), .i_host_rd_n(rd_n), .o_strip_mem_addr(addr),
        .i_strip_mem_data(sm_in), .o_strip_mem_data(sm_out), .o_strip_mem_data_oe(sm_oe),
        .o_strip_mem_write_n(we_n), .o_strip_mem_output_n(oe_n), .i_codec_byte_bus(w_byte),
        .o_codec_byte_bus(b_out), .o_codec_byte_bus_oe(b_oe), .i_block_sync_n(w_sync_n),
        .o_block_sync_n(d_sync_n), .o_block_sync_oe(s_oe), .i_stop_n(w_stop_n),
        .o_stop_n(d_stop_n), .o_stop_oe(st_oe), .i_end_of_scan_n(w_eos_n),
        .o_end_of_scan_n(d_eos_n), .o_end_of_scan_oe(e_oe), .i_codec_output_enable(c_coe));

    rbc_codec_model i_rbc_codec_model (.i_mclk(i_mclk), .i_mode(mode), .o_coe(c_coe),
        .i_byte(w_byte), .o_byte(c_byte), .i_sync_n(w_sync_n), .o_sync_n(c_sync_n),
        .i_stop_n(w_stop_n), .o_stop_n(c_stop_n), .i_eos_n(w_eos_n), .o_eos_n(c_eos_n));

    task automatic fail(string m);
        n_mismatch++;
        $display("unexpected at %0t: %s", $time, m);
    endtask
    task automatic chk_bit(logic g, logic e, string m);
        checked++;
        if (g !== e) fail(m);
    endtask
    task automatic chk_byte(logic [7:0] g, logic [7:0] e, string m);
        checked++;
        if (g !== e) fail(m);
    endtask
    task automatic chk_word(logic [15:0] g, logic [15:0] e, string m);
        checked++;
        if (g !== e) fail(m);
    endtask
    task automatic summarize;
        $display("mismatches %0d, comparisons %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic give_up(string m);
        fail(m);
        summarize();
    endtask
    task automatic tick(int n);
        repeat (n) @(negedge i_mclk);
    endtask
    // strobes stay low and high three cycles or more for the host synchroniser
    task automatic host_wr(logic [1:0] a, logic [7:0] d);
        haddr = a;
        px_drv[7:0] = d;
        hsel = 1'b1;
        tick(2);
        wr_n = 1'b0;
        tick(4);
        wr_n = 1'b1;
        tick(5);
        hsel = 1'b0;
        tick(1);
    endtask
    task automatic host_rd(logic [1:0] a, logic [7:0] e);
        haddr = a;
        hsel = 1'b1;
        tick(2);
        rd_n = 1'b0;
        tick(5);
        chk_bit(px_oe, 1'b1, "host read not driven");
        chk_word(px_out, {8'h00, e}, "host read value");
        rd_n = 1'b1;
        tick(5);
        hsel = 1'b0;
        tick(4);
        chk_bit(px_oe, 1'b0, "pixel bus left driven");
    endtask

    initial begin
        logic [7:0] v;
        // a real falling edge, so the asynchronous reset acts before the first clock
        #1 i_rst_n = 1'b0;
        void'($urandom(43816));
        tick(6);
        chk_bit(b_oe, 1'b0, "byte bus driven in reset");
        i_rst_n = 1'b1;
        tick(3);
        chk_bit(px_oe, 1'b0, "pixel bus driven while idle");
        for (int a = 1; a < 3; a++) begin
            v = 8'($urandom);
            host_wr(2'(a), v);
            host_rd(2'(a), v);
            host_wr(2'(a), 8'h00);
        end
        i_rbc_codec_model.hold_off = 1'b1;
        host_wr(`RBC_REG_MODE, 8'h01);
        frame_en = 1'b1;
        line_en = 1'b1;
        for (int k = 0; k < 32; k++) begin
            px_drv = 16'($urandom);
            wexp.push_back(px_drv);
            tick(1);
        end
        line_en = 1'b0;
        frame_en = 1'b0;
        tick(40);
        chk_byte(8'(n_sync), 8'h00, "block started under stop");
        i_rbc_codec_model.hold_off = 1'b0;
        for (int k = 0; k < 3000 && i_rbc_codec_model.rx_q.size() < 64; k++) tick(1);
        if (i_rbc_codec_model.rx_q.size() < 64) give_up("no block from device");
        tick(4);
        for (int k = 0; k < 32; k++) begin
            chk_word(wlog[k], wexp[k], "strip write word");
            chk_byte(i_rbc_codec_model.rx_q[2*k], wexp[k][7:0], "block byte");
            chk_byte(i_rbc_codec_model.rx_q[2*k+1], wexp[k][15:8], "block byte");
        end
        chk_byte(8'(i_rbc_codec_model.rx_q.size()), 8'h40, "block length");
        chk_byte(8'(i_rbc_codec_model.eos_at), 8'h40, "end of scan place");
        chk_byte(8'(n_sync), 8'h01, "sync count");
        mode = 1'b0;
        host_wr(`RBC_REG_MODE, 8'h01);
        for (int k = 0; k < 64; k++) bexp[k] = 8'($urandom);
        i_rbc_codec_model.send_blk(bexp);
        chk_byte(8'(i_rbc_codec_model.n_to), 8'h00, "stop never released");
        host_wr(`RBC_REG_MODE, 8'h01);
        tick(2);
        chk_bit(px_oe, 1'b1, "pixel bus not driven");
        exp_ph = 1'b1;
        frame_en = 1'b1;
        line_en = 1'b1;
        for (int k = 0; k < 2000 && pq.size() < 32; k++) tick(1);
        if (pq.size() < 32) give_up("pixel words missing");
        line_en = 1'b0;
        frame_en = 1'b0;
        for (int k = 0; k < 32; k++) begin
            chk_word(pq[k], {bexp[2*k+1], bexp[2*k]}, "expanded word");
        end
        i_rst_n = 1'b0;
        tick(1);
        chk_bit(px_oe | st_oe, 1'b0, "pin driven in reset");
        i_rst_n = 1'b1;
        tick(2);
        summarize();
    end
endmodule
`default_nettype wire
